// ==== logic/tbt_pkg.sv ====
// constants and types shared by the twelve-bit interval timer
package tbt_pkg;
    // ----------------------------------------------------------------
    // widths and limits
    // ----------------------------------------------------------------
    localparam int CNT_W = 12;
    localparam int FLAG_W = 4;
    localparam int ADDR_W = 4;
    localparam int DIV_W = 14;
    localparam logic [11:0] CNT_MAX = 12'hfff;
    localparam logic [11:0] CNT_ZERO = 12'h000;

    // ----------------------------------------------------------------
    // flag register addresses and bit positions
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CLOCK_SELECT = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h1;
    localparam logic [3:0] REG_OVERFLOW_STATUS = 4'hd;
    localparam int CLOCK_CHOICE_POS = 0;
    localparam int RUN_ENABLE_POS = 0;
    localparam int COUNTER_CLEAR_POS = 1;
    localparam int REPEAT_MODE_POS = 2;
    localparam int OVERFLOW_STATUS_POS = 0;

    // ----------------------------------------------------------------
    // peripheral addresses reached through the transfer buffer
    // ----------------------------------------------------------------
    localparam logic [3:0] PER_COUNT_VALUE = 4'h1;
    localparam logic [3:0] PER_MODULO_VALUE = 4'h2;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic CLOCK_CHOICE_RST = 1'b0;
    localparam logic RUN_ENABLE_RST = 1'b0;
    localparam logic REPEAT_MODE_RST = 1'b0;
    localparam logic OVERFLOW_RST = 1'b0;
    localparam logic [11:0] MODULO_RST = 12'h000;
    localparam logic [11:0] IRQ_VECTOR = 12'h003;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CORE_PERIOD_NS = 5;
    localparam int BASE_FAST_PERIOD_NS = 10000;
    localparam int BASE_SLOW_PERIOD_NS = 50000;
    localparam int DIV_FAST_CYC = BASE_FAST_PERIOD_NS / CORE_PERIOD_NS;
    localparam int DIV_SLOW_CYC = BASE_SLOW_PERIOD_NS / CORE_PERIOD_NS;

    typedef enum logic {TBT_FREE_RUN, TBT_MODULO} tbt_mode_t;
endpackage

// ==== logic/tbt_core_if.sv ====
// signals between the timer register file and its counter core
`timescale 1ns/1ps
interface tbt_core_if;
    logic tick;
    logic clear;
    logic load;
    logic [11:0] load_value;
    tbt_pkg::tbt_mode_t mode;
    logic [11:0] modulo;
    logic [11:0] count;
    logic match;
    logic ovf;

    modport ctl (output tick, output clear, output load, output load_value, output mode,
        output modulo, input count, input match, input ovf);
    modport core (input tick, input clear, input load, input load_value, input mode,
        input modulo, output count, output match, output ovf);
endinterface

// ==== logic/tbt_tick_gen.sv ====
// free-running divider that emits one-cycle basic clock ticks
`timescale 1ns/1ps
module tbt_tick_gen #(
    parameter int DIV = 2000
) (
    input wire logic core_clk, // core clock
    input wire logic rst,      // asynchronous reset
    output logic tick          // one-cycle pulse every DIV cycles
);
    logic [13:0] cnt;
    logic [13:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_tick = (cnt == 14'(DIV - 1));
        next_cnt = next_tick ? 14'h0000 : cnt + 14'h0001;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 14'h0000;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// ==== logic/tbt_counter.sv ====
// twelve-bit up-counter with compare, restart and overflow stop
`timescale 1ns/1ps
module tbt_counter (
    input wire logic core_clk, // core clock
    input wire logic rst,      // asynchronous reset
    tbt_core_if.core bus       // controls in, count and events out
);
    logic [11:0] next_count;
    logic next_match;
    logic next_ovf;
    logic [11:0] inc;

    always_comb begin
        inc = bus.count + 12'h001;
        next_count = bus.count;
        next_match = 1'b0;
        next_ovf = bus.ovf;
        if (bus.clear) begin
            next_count = tbt_pkg::CNT_ZERO;
            next_ovf = tbt_pkg::OVERFLOW_RST;
        end else if (bus.load) begin
            next_count = bus.load_value;
        end else if (bus.tick && !bus.ovf) begin
            if (bus.count == tbt_pkg::CNT_MAX) begin
                next_ovf = 1'b1;
            end else begin
                next_count = inc;
                if (inc == bus.modulo) begin
                    next_match = 1'b1;
                    if (bus.mode == tbt_pkg::TBT_MODULO) begin
                        next_count = tbt_pkg::CNT_ZERO;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus.count <= tbt_pkg::CNT_ZERO;
            bus.match <= 1'b0;
            bus.ovf <= tbt_pkg::OVERFLOW_RST;
        end else begin
            bus.count <= next_count;
            bus.match <= next_match;
            bus.ovf <= next_ovf;
        end
    end
endmodule

// ==== logic/tbt_timer_top.sv ====
// twelve-bit interval timer: flag registers, transfer path, clock choice
`timescale 1ns/1ps
module tbt_timer_top #(
    parameter int DIV_FAST = tbt_pkg::DIV_FAST_CYC, // core cycles per 100 kHz tick
    parameter int DIV_SLOW = tbt_pkg::DIV_SLOW_CYC  // core cycles per 20 kHz tick
) (
    input wire logic core_clk,           // 200 MHz core clock
    input wire logic rst,                // asynchronous power-on reset
    input wire logic [3:0] reg_addr,     // flag register address
    input wire logic reg_wr,             // flag register write strobe
    input wire logic reg_rd,             // flag register read strobe
    input wire logic [3:0] reg_wdata,    // flag register write data
    output logic [3:0] reg_rdata,        // flag register read data
    output logic reg_rvalid,             // read data valid pulse
    input wire logic [3:0] per_addr,     // peripheral address for put and get
    input wire logic dbf_put,            // put strobe from transfer buffer
    input wire logic dbf_get,            // get strobe into transfer buffer
    input wire logic [11:0] dbf_wdata,   // put data
    output logic [11:0] dbf_rdata,       // get data
    output logic dbf_rvalid,             // get data valid pulse
    output logic irq_req,                // interrupt request pulse
    output logic [11:0] irq_vector       // program vector of this interrupt
);
    // ----------------------------------------------------------------
    // basic clock generation and choice
    // ----------------------------------------------------------------
    logic tick_fast;
    logic tick_slow;
    logic tick_sel;

    tbt_tick_gen #(.DIV(DIV_FAST)) u_tick_fast (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick_fast)
    );

    tbt_tick_gen #(.DIV(DIV_SLOW)) u_tick_slow (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick_slow)
    );

    // ----------------------------------------------------------------
    // flag registers
    // ----------------------------------------------------------------
    logic clock_choice_bit;
    logic run_enable_bit;
    logic repeat_mode_bit;
    logic [11:0] modulo_value_register;
    logic next_clock_choice_bit;
    logic next_run_enable_bit;
    logic next_repeat_mode_bit;
    logic [11:0] next_modulo_value_register;
    logic wr_clock_select;
    logic wr_control;
    logic counter_clear_bit;
    logic put_count;
    logic put_modulo;

    tbt_core_if bus ();

    always_comb begin
        wr_clock_select = reg_wr && (reg_addr == tbt_pkg::REG_CLOCK_SELECT);
        wr_control = reg_wr && (reg_addr == tbt_pkg::REG_CONTROL);
        counter_clear_bit = wr_control && reg_wdata[tbt_pkg::COUNTER_CLEAR_POS];
        put_count = dbf_put && (per_addr == tbt_pkg::PER_COUNT_VALUE);
        put_modulo = dbf_put && (per_addr == tbt_pkg::PER_MODULO_VALUE);
        next_clock_choice_bit = clock_choice_bit;
        next_run_enable_bit = run_enable_bit;
        next_repeat_mode_bit = repeat_mode_bit;
        next_modulo_value_register = modulo_value_register;
        if (wr_clock_select) begin
            next_clock_choice_bit = reg_wdata[tbt_pkg::CLOCK_CHOICE_POS];
        end
        if (wr_control) begin
            next_run_enable_bit = reg_wdata[tbt_pkg::RUN_ENABLE_POS];
            next_repeat_mode_bit = reg_wdata[tbt_pkg::REPEAT_MODE_POS];
        end
        if (put_modulo) begin
            next_modulo_value_register = dbf_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clock_choice_bit <= tbt_pkg::CLOCK_CHOICE_RST;
            run_enable_bit <= tbt_pkg::RUN_ENABLE_RST;
            repeat_mode_bit <= tbt_pkg::REPEAT_MODE_RST;
            modulo_value_register <= tbt_pkg::MODULO_RST;
        end else begin
            clock_choice_bit <= next_clock_choice_bit;
            run_enable_bit <= next_run_enable_bit;
            repeat_mode_bit <= next_repeat_mode_bit;
            modulo_value_register <= next_modulo_value_register;
        end
    end

    // ----------------------------------------------------------------
    // counter core
    // ----------------------------------------------------------------
    // prescalers run free, so a switch or a start lands on the next tick
    always_comb begin
        tick_sel = clock_choice_bit ? tick_fast : tick_slow;
        bus.tick = tick_sel && run_enable_bit;
        bus.clear = counter_clear_bit;
        bus.load = put_count;
        bus.load_value = dbf_wdata;
        bus.mode = repeat_mode_bit ? tbt_pkg::TBT_MODULO : tbt_pkg::TBT_FREE_RUN;
        bus.modulo = modulo_value_register;
    end

    tbt_counter u_counter (
        .core_clk(core_clk),
        .rst(rst),
        .bus(bus)
    );

    assign irq_req = bus.match;

    // ----------------------------------------------------------------
    // read paths
    // ----------------------------------------------------------------
    logic [3:0] next_reg_rdata;
    logic [11:0] next_dbf_rdata;

    always_comb begin
        next_reg_rdata = reg_rdata;
        next_dbf_rdata = dbf_rdata;
        if (reg_rd) begin
            case (reg_addr)
                tbt_pkg::REG_CLOCK_SELECT: next_reg_rdata = {3'h0, clock_choice_bit};
                // clear bit position always returns zero
                tbt_pkg::REG_CONTROL: next_reg_rdata = {1'b0, repeat_mode_bit, 1'b0,
                    run_enable_bit};
                tbt_pkg::REG_OVERFLOW_STATUS: next_reg_rdata = {3'h0, bus.ovf};
                default: next_reg_rdata = 4'h0;
            endcase
        end
        if (dbf_get) begin
            case (per_addr)
                tbt_pkg::PER_COUNT_VALUE: next_dbf_rdata = bus.count;
                tbt_pkg::PER_MODULO_VALUE: next_dbf_rdata = modulo_value_register;
                default: next_dbf_rdata = 12'h000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 4'h0;
            reg_rvalid <= 1'b0;
            dbf_rdata <= 12'h000;
            dbf_rvalid <= 1'b0;
            irq_vector <= tbt_pkg::IRQ_VECTOR;
        end else begin
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= reg_rd;
            dbf_rdata <= next_dbf_rdata;
            dbf_rvalid <= dbf_get;
            irq_vector <= tbt_pkg::IRQ_VECTOR;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic plain_step;
    logic [11:0] step_inc;
    logic [3:0] rd_addr_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_addr_q <= 4'h0;
        end else begin
            rd_addr_q <= reg_addr;
        end
    end

    always_comb begin
        step_inc = bus.count + 12'h001;
        plain_step = bus.tick && !bus.ovf && !bus.clear && !bus.load
            && (bus.count != tbt_pkg::CNT_MAX);
    end

    a_tick_source: assert property (bus.tick |-> run_enable_bit
        && ((clock_choice_bit && tick_fast) || (!clock_choice_bit && tick_slow)))
        else $error("tick taken from the wrong basic clock");

    a_fast_tick_gap: assert property (tick_fast |=> !tick_fast [*8])
        else $error("basic clock ticks too close together");

    a_halt_when_off: assert property (!run_enable_bit && !bus.clear && !bus.load
        |=> bus.count == $past(bus.count))
        else $error("counter moved while run enable was low");

    a_clear_zeroes: assert property (bus.clear |=> bus.count == 12'h000 && !bus.ovf)
        else $error("counter clear did not zero the count");

    a_clear_reads_zero: assert property (reg_rvalid && rd_addr_q == tbt_pkg::REG_CONTROL
        |-> reg_rdata[1] == 1'b0)
        else $error("counter clear bit read back as one");

    a_free_run_pass: assert property (plain_step && !repeat_mode_bit
        |=> bus.count == $past(step_inc))
        else $error("free-running count did not step by one");

    a_modulo_restart: assert property (plain_step && repeat_mode_bit
        && step_inc == modulo_value_register |=> bus.count == 12'h000 && irq_req)
        else $error("modulo match did not restart the count");

    a_match_irq: assert property (plain_step && step_inc == modulo_value_register
        |=> irq_req ##1 !irq_req)
        else $error("match did not raise a one-cycle request");

    a_irq_cause: assert property (irq_req |-> $past(plain_step)
        && $past(step_inc) == $past(modulo_value_register))
        else $error("request raised without a match");

    a_load_count: assert property (bus.load && !bus.clear
        |=> bus.count == $past(dbf_wdata))
        else $error("put did not load the count");

    a_get_count: assert property (dbf_get && per_addr == tbt_pkg::PER_COUNT_VALUE
        |=> dbf_rvalid && dbf_rdata == $past(bus.count))
        else $error("get returned the wrong count");

    a_ovf_read: assert property (reg_rd && reg_addr == tbt_pkg::REG_OVERFLOW_STATUS
        |=> reg_rvalid && reg_rdata == {3'h0, $past(bus.ovf)})
        else $error("overflow status read wrong");

    a_ovf_stop: assert property (bus.tick && bus.count == tbt_pkg::CNT_MAX && !bus.clear
        && !bus.load |=> bus.ovf && bus.count == tbt_pkg::CNT_MAX)
        else $error("overflow did not stop the counter");

    a_ovf_holds: assert property (bus.ovf && !bus.clear && !bus.load
        |=> $stable(bus.count) && bus.ovf)
        else $error("counter moved after overflow");

    a_vector_fixed: assert property (irq_req |-> irq_vector == 12'h003)
        else $error("wrong interrupt vector");

    // ----------------------------------------------------------------
    // register access, read path, prescaler, counter and interrupt checks
    // ----------------------------------------------------------------
    a_read_valid_pulse: assert property (1'b1
        |=> reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read strobe");

    a_get_valid_pulse: assert property (1'b1
        |=> dbf_rvalid == $past(dbf_get))
        else $error("get valid not one cycle after get strobe");

    a_rdata_holds: assert property (!reg_rd
        |=> $stable(reg_rdata))
        else $error("flag read data changed without a read");

    a_get_data_holds: assert property (!dbf_get
        |=> $stable(dbf_rdata))
        else $error("get data changed without a get");

    a_clock_select_write: assert property (wr_clock_select
        |=> clock_choice_bit == $past(reg_wdata[tbt_pkg::CLOCK_CHOICE_POS]))
        else $error("clock choice bit not written");

    a_control_write: assert property (wr_control
        |=> run_enable_bit == $past(reg_wdata[tbt_pkg::RUN_ENABLE_POS])
        && repeat_mode_bit == $past(reg_wdata[tbt_pkg::REPEAT_MODE_POS]))
        else $error("control bits not written");

    a_modulo_put: assert property (put_modulo
        |=> modulo_value_register == $past(dbf_wdata))
        else $error("put did not load the modulo value");

    a_get_modulo: assert property (dbf_get && per_addr == tbt_pkg::PER_MODULO_VALUE
        |=> dbf_rdata == $past(modulo_value_register))
        else $error("get returned the wrong modulo value");

    a_unmapped_read: assert property (reg_rd && reg_addr != tbt_pkg::REG_CLOCK_SELECT
        && reg_addr != tbt_pkg::REG_CONTROL && reg_addr != tbt_pkg::REG_OVERFLOW_STATUS
        |=> reg_rdata == 4'h0)
        else $error("unmapped flag address read nonzero");

    a_idle_count_holds: assert property (!bus.tick && !bus.clear && !bus.load
        |=> $stable(bus.count))
        else $error("count moved without a tick");

    a_irq_single: assert property (irq_req
        |=> !irq_req)
        else $error("interrupt request longer than one cycle");

    a_slow_tick_gap: assert property (tick_slow
        |=> !tick_slow [*8])
        else $error("slow basic clock ticks too close together");

    a_ovf_from_top: assert property ($rose(bus.ovf)
        |-> $past(bus.count) == tbt_pkg::CNT_MAX)
        else $error("overflow set below the all-ones count");

    a_load_no_irq: assert property (bus.load
        |=> !irq_req)
        else $error("put of the count raised a request");

    a_tick_needs_run: assert property (!run_enable_bit
        |-> !bus.tick)
        else $error("tick passed while run enable was low");

    a_free_run_match: assert property (plain_step && !repeat_mode_bit
        && step_inc == modulo_value_register
        |=> bus.count == $past(step_inc) && irq_req)
        else $error("free-running match disturbed the count");

    a_vector_const: assert property (1'b1
        |-> irq_vector == tbt_pkg::IRQ_VECTOR)
        else $error("interrupt vector not constant");

    c_modulo_match: cover property (repeat_mode_bit && irq_req);
    c_free_run_match: cover property (!repeat_mode_bit && irq_req ##1 !irq_req);
    c_overflow: cover property ($rose(bus.ovf));
    c_clock_switch: cover property (run_enable_bit && $changed(clock_choice_bit));
    c_overflow_read: cover property (reg_rvalid && rd_addr_q == tbt_pkg::REG_OVERFLOW_STATUS
        && reg_rdata[0]);
endmodule

// ==== bench/tbt_timer_top_tb_top.sv ====
// self-checking bench for the twelve-bit interval timer
`timescale 1ns/1ps
module tbt_timer_top_tb_top;
    // ----------------------------------------------------------------
    // clock, reset and design hookup
    // ----------------------------------------------------------------
    localparam int DF = 10;
    localparam int DS = 20;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_wdata = 4'h0;
    logic [3:0] reg_rdata;
    logic reg_rvalid;
    logic [3:0] per_addr = 4'h0;
    logic dbf_put = 1'b0;
    logic dbf_get = 1'b0;
    logic [11:0] dbf_wdata = 12'h000;
    logic [11:0] dbf_rdata;
    logic dbf_rvalid;
    logic irq_req;
    logic [11:0] irq_vector;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed;

    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    tbt_timer_top #(.DIV_FAST(DF), .DIV_SLOW(DS)) dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .per_addr(per_addr), .dbf_put(dbf_put),
        .dbf_get(dbf_get), .dbf_wdata(dbf_wdata), .dbf_rdata(dbf_rdata),
        .dbf_rvalid(dbf_rvalid), .irq_req(irq_req), .irq_vector(irq_vector)
    );

    // ----------------------------------------------------------------
    // compare, verdict and expectation helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // irq spacing in core cycles for a modulo value and clock choice
    function automatic int exp_period(input logic sel, input int m);
        return m * (sel ? DF : DS);
    endfunction

    // control readback: clear bit always reads zero
    function automatic logic [11:0] ctl_read(input logic [3:0] d);
        return {8'h00, 1'b0, d[2], 1'b0, d[0]};
    endfunction

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [11:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check({11'h000, reg_rvalid}, 12'h001);
        d = {8'h00, reg_rdata};
    endtask

    task automatic put(input logic [3:0] a, input logic [11:0] d);
        @(posedge core_clk);
        per_addr <= a;
        dbf_wdata <= d;
        dbf_put <= 1'b1;
        @(posedge core_clk);
        dbf_put <= 1'b0;
    endtask

    task automatic get(input logic [3:0] a, output logic [11:0] d);
        @(posedge core_clk);
        per_addr <= a;
        dbf_get <= 1'b1;
        @(posedge core_clk);
        dbf_get <= 1'b0;
        #1;
        check({11'h000, dbf_rvalid}, 12'h001);
        d = dbf_rdata;
    endtask

    task automatic wait_irq(output int at);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge core_clk);
            #1;
            if (irq_req === 1'b1) begin
                at = cyc;
                return;
            end
        end
        at = 0;
        check(12'h000, 12'h001);
    endtask

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        final_report();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [11:0] r;
        logic [11:0] v;
        logic [3:0] c;
        int m;
        int t0;
        int t1;
        seed = 32'he630;
        repeat (16) @(posedge core_clk);
        check(irq_vector, 12'h003);
        rst <= 1'b0;
        // reset values and register access kinds
        rd(tbt_pkg::REG_CLOCK_SELECT, r);
        check(r, 12'h000);
        rd(tbt_pkg::REG_CONTROL, r);
        check(r, 12'h000);
        rd(tbt_pkg::REG_OVERFLOW_STATUS, r);
        check(r, 12'h000);
        wr(tbt_pkg::REG_OVERFLOW_STATUS, 4'hf);
        rd(tbt_pkg::REG_OVERFLOW_STATUS, r);
        check(r, 12'h000);
        rd(4'h7, r);
        check(r, 12'h000);
        wr(tbt_pkg::REG_CLOCK_SELECT, 4'h1);
        rd(tbt_pkg::REG_CLOCK_SELECT, r);
        check(r, 12'h001);
        for (int i = 0; i < 8; i++) begin
            c = i[3:0] & 4'h7;
            wr(tbt_pkg::REG_CONTROL, c);
            rd(tbt_pkg::REG_CONTROL, r);
            check(r, ctl_read(c));
        end
        wr(tbt_pkg::REG_CONTROL, 4'h0);
        // random loads and readback of the count while stopped
        for (int i = 0; i < 4; i++) begin
            v = 12'($random(seed));
            put(tbt_pkg::PER_COUNT_VALUE, v);
            repeat (2 * DS) @(posedge core_clk);
            get(tbt_pkg::PER_COUNT_VALUE, r);
            check(r, v);
            check(r, v);
        end
        // both clocks and both modes with a random modulo value
        for (int sel = 0; sel < 2; sel++) begin
            for (int md = 0; md < 2; md++) begin
                m = 2 + ($random(seed) & 3);
                put(tbt_pkg::PER_MODULO_VALUE, 12'(m));
                wr(tbt_pkg::REG_CLOCK_SELECT, 4'(sel));
                wr(tbt_pkg::REG_CONTROL, {1'b0, md[0], 2'b11});
                wait_irq(t0);
                get(tbt_pkg::PER_COUNT_VALUE, r);
                check(r, md ? 12'h000 : 12'(m));
                if (md == 1) begin
                    wait_irq(t1);
                    check(12'(t1 - t0), 12'(exp_period(sel[0], m)));
                    wait_irq(t0);
                    check(12'(t0 - t1), 12'(exp_period(sel[0], m)));
                end else begin
                    repeat (2 * (sel ? DF : DS)) @(posedge core_clk);
                    get(tbt_pkg::PER_COUNT_VALUE, r);
                    check(r, 12'(m + 2));
                end
                wr(tbt_pkg::REG_CONTROL, 4'h0);
            end
        end
        // overflow stops the count; a clear releases it
        wr(tbt_pkg::REG_CLOCK_SELECT, 4'h1);
        put(tbt_pkg::PER_COUNT_VALUE, 12'hffd);
        wr(tbt_pkg::REG_CONTROL, 4'h1);
        repeat (6 * DF) @(posedge core_clk);
        rd(tbt_pkg::REG_OVERFLOW_STATUS, r);
        check(r, 12'h001);
        get(tbt_pkg::PER_COUNT_VALUE, r);
        check(r, 12'hfff);
        wr(tbt_pkg::REG_CONTROL, 4'h2);
        get(tbt_pkg::PER_COUNT_VALUE, r);
        check(r, 12'h000);
        rd(tbt_pkg::REG_OVERFLOW_STATUS, r);
        check(r, 12'h000);
        final_report();
    end
endmodule
